// ==== fct_pkg.sv ====
package fct_pkg;

    // function types and their configuration codes
    typedef enum logic [1:0]
    {
        FCT_FREQ_CNT12,
        FCT_CNT32,
        FCT_FREQ_CNT32
    } fct_func_e;

    localparam logic [7:0] FCT_CODE_FREQ_CNT12 = 8'h32;
    localparam logic [7:0] FCT_CODE_CNT32 = 8'h33;
    localparam logic [7:0] FCT_CODE_FREQ_CNT32 = 8'h34;

    // telegram byte counts per function type
    localparam logic [2:0] FCT_LEN_FREQ_CNT12 = 3'h2;
    localparam logic [2:0] FCT_LEN_CNT32 = 3'h4;
    localparam logic [2:0] FCT_LEN_FREQ_CNT32 = 3'h6;

    // first telegram byte field positions
    localparam int FCT_BIT_STATUS = 0;
    localparam int FCT_BIT_FAULT = 1;
    localparam int FCT_BIT_DIR = 3;

    // timing
    localparam int FCT_CLK_HZ = 100000000;
    localparam int FCT_CONV_TIME_MS = 50;
    localparam int FCT_PUB_TIME_US = 6500;
    localparam int FCT_CONV_CYCLES = FCT_CLK_HZ / 1000 * FCT_CONV_TIME_MS;
    localparam int FCT_PUB_CYCLES = FCT_CLK_HZ / 1000000 * FCT_PUB_TIME_US;
    localparam int FCT_MAX_FREQ_HZ = 15000;
    localparam int FCT_SLOW_FREQ_HZ = 400;

    // register map, byte addresses
    localparam logic [3:0] FCT_REG_CTRL = 4'h0;
    localparam logic [3:0] FCT_REG_STAT = 4'h4;
    localparam logic [3:0] FCT_REG_IRQ_STAT = 4'h8;
    localparam logic [3:0] FCT_REG_IRQ_CLR = 4'hC;
    localparam logic [3:0] FCT_REG_IRQ_EN = 4'h0;
    localparam logic [4:0] FCT_ADDR_IRQ_EN = 5'h10;
    localparam logic [31:0] FCT_CTRL_RESET = 32'h00000000;
    localparam logic [31:0] FCT_UNMAPPED = 32'h00000000;

    // irq status bits: 0 conversion done, 1 telegram sent
    localparam int FCT_IRQ_W = 2;

    typedef struct packed
    {
        logic [47:0] bytes;
        logic [2:0] len;
        logic [7:0] code;
    } fct_tlg_s;

    typedef struct packed
    {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } fct_avm_req_s;

endpackage

// ==== fct_sync.sv ====
`timescale 1ns/1ps
module fct_sync
#(
    parameter int W = 3
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // async in, synced out
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s1_next;
    logic [W-1:0] s2_next;

    always_comb
    begin
        s1_next = ce_i ? async_i : s1_reg;
        s2_next = ce_i ? s1_reg : s2_reg;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
        end
        else
        begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
        end
    end

    assign sync_o = s2_reg;
endmodule

// ==== fct_tick.sv ====
`timescale 1ns/1ps
module fct_tick
#(
    parameter int CYCLES = 5000000
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // one-cycle pulse every CYCLES enabled cycles
    output logic tick_o
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    always_comb
    begin
        cnt_next = cnt_reg;
        // a pending tick is held while frozen so it is not lost
        tick_next = ce_i ? 1'b0 : tick_reg;
        if (ce_i)
        begin
            if (cnt_reg == 32'(CYCLES - 1))
            begin
                cnt_next = '0;
                tick_next = 1'b1;
            end
            else
            begin
                cnt_next = cnt_reg + 32'h00000001;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;
endmodule

// ==== fct_top.sv ====
// Operation
// - one measurement channel for frequency or counting, plus a direction input
// - each conversion takes about fifty milliseconds before its result is published
// - current result goes to the bus interface every 6.5 ms, independently
// - frequency or 12-bit counter type reports configuration code 50
// - 32-bit counter type reports configuration code 51
// - combined frequency and 32-bit counter type reports configuration code 52
// - code 50: two bytes, status, fault, empty, direction, then 12-bit value
// - code 52: code-50 bytes, then 32-bit count high word then low word
// - code 51: four bytes, high word then low word of the 32-bit count
// - standard device handles input signals up to 15 kHz
// - count up always, or with direction on, down while direction is 1
// - short counter runs 0 to 4095 and wraps
`timescale 1ns/1ps
module fct_top
    import fct_pkg::*;
#(
    parameter int CONV_CYCLES = fct_pkg::FCT_CONV_CYCLES,
    parameter int PUB_CYCLES = fct_pkg::FCT_PUB_CYCLES
)
(
    // clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // field pins
    input wire logic pulse_i,
    input wire logic dir_i,
    input wire logic line_fault_detect_i,
    // avalon-mm slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // telegram to bus interface unit
    output fct_pkg::fct_tlg_s tlg_o,
    output logic tlg_valid_o,
    // interrupt
    output logic irq_o
);
    import fct_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and time bases

    logic [2:0] pins_s;
    logic conv_tick;
    logic pub_tick;

    fct_sync #(.W(3)) u_sync
    (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .async_i({line_fault_detect_i, dir_i, pulse_i}),
        .sync_o(pins_s)
    );

    fct_tick #(.CYCLES(CONV_CYCLES)) u_conv
    (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .tick_o(conv_tick)
    );

    fct_tick #(.CYCLES(PUB_CYCLES)) u_pub
    (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .tick_o(pub_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [FCT_IRQ_W-1:0] ist_reg;
    logic [FCT_IRQ_W-1:0] ist_next;
    logic [FCT_IRQ_W-1:0] ien_reg;
    logic [FCT_IRQ_W-1:0] ien_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wait_reg;
    logic wait_next;
    logic irq_reg;
    logic irq_next;

    // ctrl: [1:0] function type, [2] direction detect, [3] measurement enable
    fct_func_e func;
    logic dir_en;
    logic meas_en;
    assign func = (ctrl_reg[1:0] == 2'h3) ? FCT_FREQ_CNT12 : fct_func_e'(ctrl_reg[1:0]);
    assign dir_en = ctrl_reg[2];
    assign meas_en = ctrl_reg[3];

    ////////////////////////////////////////////////////////////////////////
    // measurement

    logic pulse_d_reg;
    logic pulse_d_next;
    logic [31:0] cnt32_reg;
    logic [31:0] cnt32_next;
    logic [11:0] cnt12_reg;
    logic [11:0] cnt12_next;
    logic [11:0] per_reg;
    logic [11:0] per_next;
    logic [11:0] freq_reg;
    logic [11:0] freq_next;
    logic [31:0] snap32_reg;
    logic [31:0] snap32_next;
    logic [11:0] snap12_reg;
    logic [11:0] snap12_next;
    logic snap_dir_reg;
    logic snap_dir_next;
    logic edge_s;
    logic down;

    // pulses per 50 ms window stand in for the frequency; 15 kHz gives 750, well inside 12 bits
    assign edge_s = pins_s[0] & ~pulse_d_reg;
    assign down = dir_en & pins_s[1];

    always_comb
    begin
        pulse_d_next = pulse_d_reg;
        cnt32_next = cnt32_reg;
        cnt12_next = cnt12_reg;
        per_next = per_reg;
        freq_next = freq_reg;
        snap32_next = snap32_reg;
        snap12_next = snap12_reg;
        snap_dir_next = snap_dir_reg;
        if (ce_i && meas_en)
        begin
            pulse_d_next = pins_s[0];
            if (edge_s)
            begin
                cnt32_next = down ? cnt32_reg - 32'h00000001 : cnt32_reg + 32'h00000001;
                cnt12_next = down ? cnt12_reg - 12'h001 : cnt12_reg + 12'h001;
                per_next = (per_reg == 12'hFFF) ? per_reg : per_reg + 12'h001;
            end
            if (conv_tick)
            begin
                // result counts pulses in a 50 ms window, saturating at 4095
                freq_next = per_next;
                per_next = 12'h000;
                snap32_next = cnt32_next;
                snap12_next = cnt12_next;
                snap_dir_next = pins_s[1];
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            pulse_d_reg <= 1'b0;
            cnt32_reg <= '0;
            cnt12_reg <= '0;
            per_reg <= '0;
            freq_reg <= '0;
            snap32_reg <= '0;
            snap12_reg <= '0;
            snap_dir_reg <= 1'b0;
        end
        else
        begin
            pulse_d_reg <= pulse_d_next;
            cnt32_reg <= cnt32_next;
            cnt12_reg <= cnt12_next;
            per_reg <= per_next;
            freq_reg <= freq_next;
            snap32_reg <= snap32_next;
            snap12_reg <= snap12_next;
            snap_dir_reg <= snap_dir_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // telegram assembly, byte 1 in bits [47:40]

    fct_tlg_s tlg_reg;
    fct_tlg_s tlg_next;
    logic tv_reg;
    logic tv_next;
    logic [7:0] b1;
    logic [11:0] val12;

    assign val12 = (func == FCT_FREQ_CNT32) ? freq_reg : snap12_reg;
    always_comb
    begin
        b1 = 8'h00;
        b1[FCT_BIT_STATUS] = pins_s[0];
        b1[FCT_BIT_FAULT] = pins_s[2];
        b1[FCT_BIT_DIR] = snap_dir_reg & dir_en;
        b1[7:4] = val12[11:8];
    end

    always_comb
    begin
        tlg_next = tlg_reg;
        tv_next = ce_i ? 1'b0 : tv_reg;
        if (ce_i && pub_tick)
        begin
            tv_next = 1'b1;
            case (func)
                FCT_CNT32:
                begin
                    tlg_next.code = FCT_CODE_CNT32;
                    tlg_next.len = FCT_LEN_CNT32;
                    tlg_next.bytes = {snap32_reg, 16'h0000};
                end
                FCT_FREQ_CNT32:
                begin
                    tlg_next.code = FCT_CODE_FREQ_CNT32;
                    tlg_next.len = FCT_LEN_FREQ_CNT32;
                    tlg_next.bytes = {b1, val12[7:0], snap32_reg};
                end
                default:
                begin
                    tlg_next.code = FCT_CODE_FREQ_CNT12;
                    tlg_next.len = FCT_LEN_FREQ_CNT12;
                    tlg_next.bytes = {b1, val12[7:0], 32'h00000000};
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            tlg_reg <= '0;
            tv_reg <= 1'b0;
        end
        else
        begin
            tlg_reg <= tlg_next;
            tv_reg <= tv_next;
        end
    end

    assign tlg_o = tlg_reg;
    assign tlg_valid_o = tv_reg;

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle; reads fetch one cycle ahead so readdata comes from a register

    logic acc;
    logic [FCT_IRQ_W-1:0] ev;
    assign acc = (avs_read_i | avs_write_i) & wait_reg;
    assign ev = {tv_next, ce_i & meas_en & conv_tick};

    always_comb
    begin
        ctrl_next = ctrl_reg;
        ien_next = ien_reg;
        ist_next = ist_reg;
        rdata_next = rdata_reg;
        wait_next = 1'b1;
        if (ce_i)
        begin
            if ((avs_read_i | avs_write_i) && wait_reg)
            begin
                wait_next = 1'b0;
            end
            // writes land only on the edge that sees waitrequest low
            if (avs_write_i && !wait_reg)
            begin
                case (avs_address_i)
                    {1'b0, FCT_REG_CTRL}: ctrl_next = avs_writedata_i;
                    {1'b0, FCT_REG_IRQ_CLR}: ist_next = ist_reg & ~avs_writedata_i[FCT_IRQ_W-1:0];
                    FCT_ADDR_IRQ_EN: ien_next = avs_writedata_i[FCT_IRQ_W-1:0];
                    default: ;
                endcase
            end
            if (acc && avs_read_i)
            begin
                case (avs_address_i)
                    {1'b0, FCT_REG_CTRL}: rdata_next = ctrl_reg;
                    {1'b0, FCT_REG_STAT}: rdata_next = {20'h00000, freq_reg};
                    {1'b0, FCT_REG_IRQ_STAT}: rdata_next = {30'h00000000, ist_reg};
                    FCT_ADDR_IRQ_EN: rdata_next = {30'h00000000, ien_reg};
                    5'h14: rdata_next = snap32_reg;
                    default: rdata_next = FCT_UNMAPPED;
                endcase
            end
            // set wins over clear
            ist_next = ist_next | ev;
        end
        else
        begin
            wait_next = wait_reg;
        end
        irq_next = |(ist_next & ien_next);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            ctrl_reg <= FCT_CTRL_RESET;
            ien_reg <= '0;
            ist_reg <= '0;
            rdata_reg <= '0;
            wait_reg <= 1'b1;
            irq_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            ien_reg <= ien_next;
            ist_reg <= ist_next;
            rdata_reg <= rdata_next;
            wait_reg <= wait_next;
            irq_reg <= irq_next;
        end
    end

    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign irq_o = irq_reg;
endmodule

// ==== fct_top_assertions.sv ====
`timescale 1ns/1ps
module fct_top_assertions
#(
    parameter int PUB_CYCLES = 20
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // watched pins
    input wire logic line_fault_detect_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire fct_pkg::fct_tlg_s tlg_o,
    input wire logic tlg_valid_o
);
    import fct_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////
    // enabled cycles since the last publish; a stalled enable does not count
    int gap_reg;
    int gap_next;
    logic seen_reg;
    logic seen_next;
    always_comb
    begin
        gap_next = tlg_valid_o ? 0 : (ce_i ? gap_reg + 1 : gap_reg);
        seen_next = seen_reg | tlg_valid_o;
    end
    always_ff @(posedge sys_clk_i)
    begin
        gap_reg <= nrst_i ? gap_next : 0;
        seen_reg <= nrst_i & seen_next;
    end
    ////////////////////////////////////////////////////////////////
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i;
    endsequence
    // fault level must settle through the synchroniser before it is judged
    sequence s_calm;
        $stable(line_fault_detect_i) [*6];
    endsequence
    a_pub_exact: assert property (tlg_valid_o && seen_reg |-> gap_reg == PUB_CYCLES - 1)
        else $error("publish period wrong");
    a_pub_due: assert property (seen_reg |-> gap_reg < PUB_CYCLES)
        else $error("publish overdue");
    a_valid_pulse: assert property (tlg_valid_o && ce_i |=> !tlg_valid_o)
        else $error("valid longer than one cycle");
    a_tlg_stable: assert property ($past(nrst_i) && !tlg_valid_o |-> $stable(tlg_o))
        else $error("telegram changed between publishes");
    a_code_len: assert property (tlg_valid_o |->
        (tlg_o.code == FCT_CODE_FREQ_CNT12 && tlg_o.len == FCT_LEN_FREQ_CNT12)
        || (tlg_o.code == FCT_CODE_CNT32 && tlg_o.len == FCT_LEN_CNT32)
        || (tlg_o.code == FCT_CODE_FREQ_CNT32 && tlg_o.len == FCT_LEN_FREQ_CNT32))
        else $error("code and length disagree");
    a_empty_bit: assert property (tlg_valid_o && tlg_o.code != FCT_CODE_CNT32 |-> !tlg_o.bytes[42])
        else $error("empty bit set");
    a_fault_bit: assert property (s_calm ##0 (tlg_valid_o && tlg_o.code != FCT_CODE_CNT32)
        |-> tlg_o.bytes[41] == line_fault_detect_i)
        else $error("fault bit wrong");
    a_wait_one: assert property (s_req |=> !avs_waitrequest_o)
        else $error("no answer after one cycle");
    a_wait_once: assert property (!avs_waitrequest_o && ce_i |=> avs_waitrequest_o)
        else $error("answer held too long");
    a_idle_wait: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer without request");
endmodule
bind fct_top fct_top_assertions #(.PUB_CYCLES(PUB_CYCLES)) i_fct_top_assertions (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .line_fault_detect_i(line_fault_detect_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o),
    .tlg_o(tlg_o),
    .tlg_valid_o(tlg_valid_o)
);

// ==== fct_biu_model.sv ====
`timescale 1ns/1ps
module fct_biu_model
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // telegram from the module
    input wire fct_pkg::fct_tlg_s tlg_i,
    input wire logic tlg_valid_i,
    // configuration held by the master
    input wire logic [7:0] cfg_code_i,
    // last accepted telegram
    output fct_pkg::fct_tlg_s last_o,
    output int count_o,
    output logic cfg_bad_o
);
    import fct_pkg::*;
    // a foreign code refuses the exchange, so stale data stays visible
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            last_o <= '0;
            count_o <= 0;
            cfg_bad_o <= 1'b0;
        end
        else if (tlg_valid_i)
        begin
            count_o <= count_o + 1;
            cfg_bad_o <= tlg_i.code !== cfg_code_i;
            if (tlg_i.code === cfg_code_i) last_o <= tlg_i;
        end
    end
endmodule

// ==== test_freq_counter_input_telegram.sv ====
`timescale 1ns/1ps
module test_freq_counter_input_telegram;
    import fct_pkg::*;
    logic sys_clk_i = 1'b0;
    logic nrst_i;
    logic ce_i;
    logic pulse_i;
    logic dir_i;
    logic line_fault_detect_i;
    logic [4:0] avs_address_i;
    logic avs_read_i;
    logic avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    fct_tlg_s tlg_o;
    logic tlg_valid_o;
    logic irq_o;
    fct_tlg_s last;
    int tcount;
    logic cfg_bad;
    logic [7:0] cfg_code;
    logic [31:0] q;
    int fail_count;
    int total_checks;
    localparam logic [4:0] CTRL = {1'b0, FCT_REG_CTRL};
    localparam int CONV = 50;
    localparam int PUB = 20;
    always #5 sys_clk_i = ~sys_clk_i;
    fct_top #(.CONV_CYCLES(CONV), .PUB_CYCLES(PUB)) i_fct_top (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .pulse_i(pulse_i), .dir_i(dir_i), .line_fault_detect_i(line_fault_detect_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .tlg_o(tlg_o), .tlg_valid_o(tlg_valid_o), .irq_o(irq_o));
    fct_biu_model i_fct_biu_model (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .tlg_i(tlg_o),
        .tlg_valid_i(tlg_valid_o), .cfg_code_i(cfg_code), .last_o(last), .count_o(tcount), .cfg_bad_o(cfg_bad));
    ////////////////////////////////////////////////////////////////
    task cmp(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    // the master waits as long as the slave asks; only the watchdog ends it
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= d;
        @(posedge sys_clk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge sys_clk_i);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task pulses(input int n);
        repeat (n)
        begin
            @(posedge sys_clk_i);
            pulse_i <= 1'b1;
            repeat (3) @(posedge sys_clk_i);
            pulse_i <= 1'b0;
            repeat (2) @(posedge sys_clk_i);
        end
    endtask
    task wait_tlg(input int n);
        int c;
        c = tcount + n;
        while (tcount < c) @(posedge sys_clk_i);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task t_reset;
        bus(1'b0, CTRL, 32'h0);
        cmp(48'(q), 48'(FCT_CTRL_RESET));
    endtask
    task t_cnt32;
        dir_i <= 1'b1;
        cfg_code <= FCT_CODE_CNT32;
        bus(1'b1, CTRL, 32'h0000000D);
        pulses(3);
        wait_tlg(5);
        cmp(48'({last.code, last.len}), 48'({FCT_CODE_CNT32, FCT_LEN_CNT32}));
        cmp(48'(last.bytes[47:16]), 48'hFFFFFFFD);
        bus(1'b0, 5'h14, 32'h0);
        cmp(48'(q), 48'hFFFFFFFD);
        // readdata is nonzero here, so an unmapped read must really clear it
        bus(1'b0, 5'h18, 32'h0);
        cmp(48'(q), 48'(FCT_UNMAPPED));
        cmp(48'(cfg_bad), 48'h0);
    endtask
    task t_cnt12;
        cfg_code <= FCT_CODE_FREQ_CNT12;
        line_fault_detect_i <= 1'b1;
        bus(1'b1, CTRL, 32'h0000000C);
        wait_tlg(3);
        cmp(48'({last.code, last.len}), 48'({FCT_CODE_FREQ_CNT12, FCT_LEN_FREQ_CNT12}));
        cmp(48'(last.bytes[47:32]), 48'hFAFD);
        dir_i <= 1'b0;
        pulses(5);
        bus(1'b1, CTRL, 32'h00000008);
        dir_i <= 1'b1;
        line_fault_detect_i <= 1'b0;
        pulses(2);
        wait_tlg(5);
        cmp(48'(last.bytes[47:32]), 48'h0004);
    endtask
    task t_cnt52;
        cfg_code <= FCT_CODE_FREQ_CNT32;
        bus(1'b1, CTRL, 32'h0000000A);
        wait_tlg(6);
        cmp(48'({last.code, last.len}), 48'({FCT_CODE_FREQ_CNT32, FCT_LEN_FREQ_CNT32}));
        cmp(last.bytes, 48'h000000000004);
        cfg_code <= FCT_CODE_FREQ_CNT12;
        bus(1'b1, CTRL, 32'h0000000B);
        wait_tlg(3);
        cmp(48'({last.code, last.len}), 48'({FCT_CODE_FREQ_CNT12, FCT_LEN_FREQ_CNT12}));
    endtask
    // align to a conversion tick, then put a known number of pulses into one window
    task t_freq;
        bus(1'b1, {1'b0, FCT_REG_IRQ_CLR}, 32'h1);
        q = 32'h0;
        while (q[0] !== 1'b1) bus(1'b0, {1'b0, FCT_REG_IRQ_STAT}, 32'h0);
        pulses(3);
        repeat (CONV) @(posedge sys_clk_i);
        bus(1'b0, {1'b0, FCT_REG_STAT}, 32'h0);
        cmp(48'(q), 48'h3);
    endtask
    // dropped just after a publish so no valid pulse is in flight
    task t_freeze;
        int c;
        wait_tlg(1);
        c = tcount;
        ce_i <= 1'b0;
        repeat (3 * PUB) @(posedge sys_clk_i);
        cmp(48'(tcount), 48'(c));
        ce_i <= 1'b1;
        wait_tlg(1);
    endtask
    task t_irq;
        bus(1'b1, FCT_ADDR_IRQ_EN, 32'h0);
        wait_tlg(3);
        bus(1'b0, {1'b0, FCT_REG_IRQ_STAT}, 32'h0);
        cmp(48'(q[1:0]), 48'h3);
        cmp(48'(irq_o), 48'h0);
        bus(1'b1, FCT_ADDR_IRQ_EN, 32'h1);
        repeat (2) @(posedge sys_clk_i);
        cmp(48'(irq_o), 48'h1);
        bus(1'b0, FCT_ADDR_IRQ_EN, 32'h0);
        cmp(48'(q), 48'h1);
        // clear right after a publish, away from the next conversion tick
        wait_tlg(1);
        bus(1'b1, {1'b0, FCT_REG_IRQ_CLR}, 32'h3);
        repeat (2) @(posedge sys_clk_i);
        cmp(48'(irq_o), 48'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        nrst_i = 1'b0;
        ce_i = 1'b1;
        pulse_i = 1'b0;
        dir_i = 1'b0;
        line_fault_detect_i = 1'b0;
        avs_address_i = 5'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        cfg_code = FCT_CODE_FREQ_CNT12;
        fail_count = 0;
        total_checks = 0;
        repeat (10) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        t_reset;
        t_cnt32;
        t_cnt12;
        t_cnt52;
        t_freq;
        t_freeze;
        t_irq;
        summarize;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        summarize;
    end
endmodule
